// ==== ifb_fetch.sv ====
// ifb_fetch.sv - instruction fetch front end with buffer, cache, TLB and predictor
// Functional notes
// - buffer: four decode plus two fetch words
// - keep fetching as decode drains buffer
// - leftover instructions shift to entry zero
// - at most one aligned doubleword per cycle
// - no read on TLB/cache miss, fetch nonempty
// - odd word target delivers one instruction
// - fill decode first, overflow to fetch
// - increment fetch PC when not taken
// - taken prediction loads predicted target
// - misprediction redirect loads correct target
// - indirect branches predicted through stored targets
// - two-bit saturating counter per branch
// - correctly predicted branch costs no stall
// - 2KB direct-mapped cache, 32-byte lines
// - four-entry associative ITLB, hardware refill
// - four block translations checked first
`timescale 1ns/100ps
module ifb_fetch (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    // decode side
    output logic [3:0][31:0] o_dec_words,
    output logic [2:0] o_dec_cnt,
    input wire logic [1:0] i_dec_take,
    input wire logic i_redirect,
    input wire logic [31:0] i_redirect_pc,
    input wire ifb_pkg::ifb_bru_upd_t i_bru_upd,
    output logic [31:0] o_fetch_pc,
    // instruction TLB refill
    output logic o_itlb_req,
    output logic [31:0] o_itlb_ea,
    input wire logic i_itlb_fill_valid,
    input wire ifb_pkg::ifb_itlb_ent_t i_itlb_fill,
    // block translation
    input wire ifb_pkg::ifb_ibt_ent_t [3:0] i_insn_block_translation_regs,
    // cache refill
    output logic o_icm_req,
    output logic [26:0] o_icm_line,
    input wire logic i_fill_valid,
    input wire logic [63:0] i_fill_data,
    output logic o_fill_ready
);
    import ifb_pkg::*;

    typedef struct packed {
        ifb_fst_t fst;
        logic [31:0] pc;
        logic [3:0][31:0] dec_w;
        logic [2:0] dec_cnt;
        logic [1:0][31:0] fb_w;
        logic [1:0] fb_cnt;
        logic tlb_req;
        logic [31:0] miss_ea;
        logic icm_req;
        logic [26:0] icm_line;
        logic [1:0] fill_cnt;
        ifb_itlb_ent_t [IFB_ITLB_ENTRIES-1:0] itlb;
        logic [1:0] itlb_ptr;
        logic [IFB_LINES-1:0] tag_vld;
        logic [IFB_FND_ENTRIES-1:0] fnd_vld;
        logic [IFB_FND_ENTRIES-1:0][1:0] fnd_ctr;
    } ifb_st_t;

    ifb_st_t r;
    ifb_st_t n;
    logic [IFB_TAG_W-1:0] tag_mem [IFB_LINES];
    logic [63:0] dat_mem [IFB_DWORDS];
    logic [31:0] tgt_mem [IFB_FND_ENTRIES];

    logic rd_en;
    logic xl_hit;
    logic [31:0] pa;
    logic c_hit;
    logic [63:0] dw;
    logic [5:0] fi0;
    logic [5:0] fi1;
    logic t0;
    logic t1;
    logic taken;
    logic [31:0] tgt;
    logic accept;
    logic two;
    logic [2:0] cons;
    logic [2:0] tot;
    logic [2:0] rem;
    logic [7:0][31:0] seq;
    logic [7:0][31:0] shf;
    logic fill_wr;
    logic [63:0] fill_dw;
    logic fill_vld;
    logic [5:0] uidx;
    logic [1:0] uctr;

    // ========================================
    // refill buffer
    ifb_fifo #(
        .WIDTH(IFB_FIFO_WIDTH),
        .DEPTH(IFB_FIFO_DEPTH)
    ) u_fifo (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_wr_valid(i_fill_valid),
        .i_wr_data(i_fill_data),
        .o_wr_ready(o_fill_ready),
        .o_rd_valid(fill_vld),
        .o_rd_data(fill_dw),
        .i_rd_ready(fill_wr)
    );

    // the single-ported array takes refill beats only while fetch waits on a miss
    assign fill_wr = (r.fst == FS_MISS) && fill_vld;

    // ========================================
    // next state
    always_comb begin
        n = r;
        // fetch only when nothing is pending and the fetch section is empty
        rd_en = (r.fst == FS_RUN) && (r.fb_cnt == 2'h0) && !i_redirect;
        // block translation has priority over the ITLB
        xl_hit = 1'b0;
        pa = r.pc;
        for (int i = 0; i < IFB_IBT_ENTRIES; i++) begin
            if (!xl_hit && i_insn_block_translation_regs[i].valid &&
                i_insn_block_translation_regs[i].bepi == r.pc[31:IFB_BLK_LSB]) begin
                xl_hit = 1'b1;
                pa = {i_insn_block_translation_regs[i].brpn, r.pc[IFB_BLK_LSB-1:0]};
            end
        end
        for (int i = 0; i < IFB_ITLB_ENTRIES; i++) begin
            if (!xl_hit && r.itlb[i].valid && r.itlb[i].epn == r.pc[31:IFB_PAGE_LSB]) begin
                xl_hit = 1'b1;
                pa = {r.itlb[i].rpn, r.pc[IFB_PAGE_LSB-1:0]};
            end
        end
        // direct-mapped lookup of one aligned doubleword
        c_hit = r.tag_vld[pa[IFB_IDX_MSB:IFB_LINE_LSB]] &&
                tag_mem[pa[IFB_IDX_MSB:IFB_LINE_LSB]] == pa[31:IFB_IDX_MSB+1];
        dw = dat_mem[pa[IFB_IDX_MSB:3]];
        // predictor lookup for both words of the doubleword
        fi0 = {r.pc[7:3], 1'b0};
        fi1 = {r.pc[7:3], 1'b1};
        t0 = !r.pc[2] && r.fnd_vld[fi0] && r.fnd_ctr[fi0][1];
        t1 = r.fnd_vld[fi1] && r.fnd_ctr[fi1][1];
        taken = t0 || t1;
        tgt = t0 ? tgt_mem[fi0] : tgt_mem[fi1];
        accept = rd_en && xl_hit && c_hit;
        // odd target or taken first word delivers a single word
        two = !r.pc[2] && !t0;
        // ---- buffer: drain, shift, append
        cons = ({1'b0, i_dec_take} > r.dec_cnt) ? r.dec_cnt : {1'b0, i_dec_take};
        tot = r.dec_cnt + {1'b0, r.fb_cnt};
        seq = '0;
        for (int k = 0; k < 4; k++) begin
            seq[k] = r.dec_w[k];
        end
        seq[4] = r.fb_w[0];
        seq[5] = r.fb_w[1];
        shf = '0;
        for (int k = 0; k < 6; k++) begin
            if (k + int'(cons) < 8) begin
                shf[k] = seq[k + int'(cons)];
            end
        end
        rem = tot - cons;
        if (accept) begin
            shf[rem] = r.pc[2] ? dw[31:0] : dw[63:32];
            if (two) begin
                shf[rem + 3'h1] = dw[31:0];
            end
            rem = rem + (two ? 3'h2 : 3'h1);
        end
        // decode section first, overflow into fetch section
        n.dec_cnt = (rem > IFB_DEC_DEPTH) ? IFB_DEC_DEPTH : rem;
        n.fb_cnt = 2'(rem - n.dec_cnt);
        for (int k = 0; k < 4; k++) begin
            n.dec_w[k] = shf[k];
        end
        n.fb_w[0] = shf[4];
        n.fb_w[1] = shf[5];
        // ---- fetch program counter
        if (i_redirect) begin
            n.pc = i_redirect_pc;
            n.dec_cnt = 3'h0;
            n.fb_cnt = 2'h0;
        end else if (accept) begin
            if (taken) begin
                n.pc = tgt;
            end else begin
                n.pc = r.pc + (two ? IFB_DWORD_STEP : IFB_WORD_STEP);
            end
        end else if (rd_en && !xl_hit) begin
            n.fst = FS_TLB;
            n.tlb_req = 1'b1;
            n.miss_ea = r.pc;
        end else if (rd_en && !c_hit) begin
            n.fst = FS_MISS;
            n.icm_req = 1'b1;
            n.icm_line = pa[31:IFB_LINE_LSB];
            n.fill_cnt = 2'h0;
        end
        // ---- ITLB refill, round robin replacement
        if (r.fst == FS_TLB && i_itlb_fill_valid) begin
            n.itlb[r.itlb_ptr] = i_itlb_fill;
            n.itlb_ptr = r.itlb_ptr + 2'h1;
            n.fst = FS_RUN;
            n.tlb_req = 1'b0;
        end
        // ---- cache refill, four beats per line
        if (fill_wr) begin
            n.fill_cnt = r.fill_cnt + 2'h1;
            if (r.fill_cnt == IFB_FILL_LAST) begin
                n.tag_vld[r.icm_line[5:0]] = 1'b1;
                n.fst = FS_RUN;
                n.icm_req = 1'b0;
            end
        end
        // ---- predictor training from the branch side
        uidx = i_bru_upd.pc[7:2];
        uctr = r.fnd_ctr[uidx];
        if (i_bru_upd.valid) begin
            n.fnd_vld[uidx] = 1'b1;
            if (!r.fnd_vld[uidx]) begin
                n.fnd_ctr[uidx] = i_bru_upd.taken ? IFB_CTR_WT : IFB_CTR_WNT;
            end else if (i_bru_upd.taken && uctr != IFB_CTR_MAX) begin
                n.fnd_ctr[uidx] = uctr + 2'h1;
            end else if (!i_bru_upd.taken && uctr != IFB_CTR_MIN) begin
                n.fnd_ctr[uidx] = uctr - 2'h1;
            end
        end
    end

    // ========================================
    // state register
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            r <= '0;
            r.fst <= FS_RUN;
            r.pc <= IFB_RESET_PC;
        end else begin
            r <= n;
        end
    end

    // ========================================
    // arrays
    always_ff @(posedge i_ref_clk) begin
        if (fill_wr) begin
            dat_mem[{r.icm_line[5:0], r.fill_cnt}] <= fill_dw;
            if (r.fill_cnt == IFB_FILL_LAST) begin
                tag_mem[r.icm_line[5:0]] <= r.icm_line[26:6];
            end
        end
        if (i_bru_upd.valid) begin
            tgt_mem[uidx] <= i_bru_upd.target;
        end
    end

    // ========================================
    // outputs
    assign o_dec_words = r.dec_w;
    assign o_dec_cnt = r.dec_cnt;
    assign o_fetch_pc = r.pc;
    assign o_itlb_req = r.tlb_req;
    assign o_itlb_ea = r.miss_ea;
    assign o_icm_req = r.icm_req;
    assign o_icm_line = r.icm_line;

    // ========================================
    // checks
    buf_size_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        r.dec_cnt <= IFB_DEC_DEPTH && r.fb_cnt <= IFB_FB_DEPTH &&
        (r.fb_cnt == 2'h0 || r.dec_cnt == IFB_DEC_DEPTH))
        else $error("instruction buffer occupancy out of range");

    read_gate_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        rd_en |-> (r.fb_cnt == 2'h0 && !r.tlb_req && !r.icm_req))
        else $error("cache read while fetch blocked");

    odd_single_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (accept && r.pc[2] && i_dec_take == 2'h0 && r.dec_cnt == 3'h0) |=> r.dec_cnt == 3'h1)
        else $error("odd target delivered more than one word");

    redirect_pc_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        i_redirect |=> r.pc == $past(i_redirect_pc))
        else $error("redirect target not loaded");

    wrong_path_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        i_redirect |=> (r.dec_cnt == 3'h0 && r.fb_cnt == 2'h0))
        else $error("wrong-path words kept after redirect");

    tlb_refill_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (r.fst == FS_TLB && i_itlb_fill_valid) |=> (!r.tlb_req && r.fst == FS_RUN))
        else $error("translation refill not taken");

    taken_pc_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (!i_redirect && accept && taken) |=> r.pc == $past(tgt))
        else $error("taken prediction target not loaded");

    step_pc_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (!i_redirect && accept && !taken) |=> r.pc == $past(r.pc) + ($past(two) ? 32'h8 : 32'h4))
        else $error("fetch pc step does not match words accepted");

    shift_head_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (!i_redirect && i_dec_take == 2'h1 && r.dec_cnt >= 3'h2) |=> o_dec_words[0] == $past(r.dec_w[1]))
        else $error("oldest remaining word not at entry zero");

    no_stall_a: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        (accept && taken && !i_redirect && i_dec_take == 2'h0 && r.dec_cnt == 3'h0) |=>
        (r.fst == FS_RUN && r.dec_cnt != 3'h0))
        else $error("taken branch lost its fetched word");

endmodule // ifb_fetch

// ==== ifb_pkg.sv ====
// ifb_pkg.sv - constants and types for the instruction fetch front end
package ifb_pkg;

    // ========================================
    // instruction buffer
    localparam logic [2:0] IFB_DEC_DEPTH = 3'h4;
    localparam logic [1:0] IFB_FB_DEPTH = 2'h2;
    localparam logic [1:0] IFB_ISSUE_MAX = 2'h3;
    localparam logic [31:0] IFB_RESET_PC = 32'h0000_0100;
    localparam logic [31:0] IFB_WORD_STEP = 32'h0000_0004;
    localparam logic [31:0] IFB_DWORD_STEP = 32'h0000_0008;

    // ========================================
    // address fields
    localparam int IFB_PAGE_LSB = 12;
    localparam int IFB_BLK_LSB = 17;
    localparam int IFB_LINE_LSB = 5;
    localparam int IFB_IDX_MSB = 10;
    localparam int IFB_TAG_W = 32 - IFB_IDX_MSB - 1;
    localparam int IFB_LINES = 64;
    localparam int IFB_DWORDS = 256;
    localparam int IFB_FND_ENTRIES = 64;
    localparam int IFB_ITLB_ENTRIES = 4;
    localparam int IFB_IBT_ENTRIES = 4;
    localparam logic [1:0] IFB_FILL_LAST = 2'h3;

    // ========================================
    // refill buffer
    localparam int IFB_FIFO_DEPTH = 32;
    localparam int IFB_FIFO_WIDTH = 64;

    // ========================================
    // two-bit prediction counter
    localparam logic [1:0] IFB_CTR_MIN = 2'h0;
    localparam logic [1:0] IFB_CTR_WNT = 2'h1;
    localparam logic [1:0] IFB_CTR_WT = 2'h2;
    localparam logic [1:0] IFB_CTR_MAX = 2'h3;

    // ========================================
    // types
    typedef enum logic [1:0] {
        FS_RUN = 2'b00,
        FS_TLB = 2'b01,
        FS_MISS = 2'b11
    } ifb_fst_t;

    typedef struct packed {
        logic valid;
        logic [31-IFB_PAGE_LSB:0] epn;
        logic [31-IFB_PAGE_LSB:0] rpn;
    } ifb_itlb_ent_t;

    typedef struct packed {
        logic valid;
        logic [31-IFB_BLK_LSB:0] bepi;
        logic [31-IFB_BLK_LSB:0] brpn;
    } ifb_ibt_ent_t;

    typedef struct packed {
        logic valid;
        logic taken;
        logic [31:0] pc;
        logic [31:0] target;
    } ifb_bru_upd_t;

endpackage

// ==== ifb_fifo.sv ====
// ifb_fifo.sv - refill data FIFO with valid/ready on both sides
`timescale 1ns/100ps
module ifb_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    // filling side
    input wire logic i_wr_valid,
    input wire logic [WIDTH-1:0] i_wr_data,
    output logic o_wr_ready,
    // draining side
    output logic o_rd_valid,
    output logic [WIDTH-1:0] o_rd_data,
    input wire logic i_rd_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [AW:0] cnt;
        logic ready;
        logic valid;
    } ifb_fifo_st_t;

    ifb_fifo_st_t st_reg;
    ifb_fifo_st_t st_next;
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic do_wr;
    logic do_rd;

    // ========================================
    // control
    always_comb begin
        st_next = st_reg;
        do_wr = i_wr_valid && st_reg.ready;
        do_rd = i_rd_ready && st_reg.valid;
        if (do_wr) begin
            st_next.wptr = st_reg.wptr + 1'b1;
        end
        if (do_rd) begin
            st_next.rptr = st_reg.rptr + 1'b1;
        end
        st_next.cnt = st_reg.cnt + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        st_next.ready = st_next.cnt != (AW+1)'(DEPTH);
        st_next.valid = st_next.cnt != '0;
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_reg <= '{wptr: '0, rptr: '0, cnt: '0, ready: 1'b1, valid: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    // ========================================
    // storage
    always_ff @(posedge i_ref_clk) begin
        if (do_wr) begin
            mem_reg[st_reg.wptr] <= i_wr_data;
        end
    end

    assign o_wr_ready = st_reg.ready;
    assign o_rd_valid = st_reg.valid;
    assign o_rd_data = mem_reg[st_reg.rptr];

endmodule // ifb_fifo

// ==== ifb_dec_unit.sv ====
// ifb_dec_unit.sv - decode and branch side model that consumes, trains and redirects
`timescale 1ns/100ps
module ifb_dec_unit (
    // clock
    input wire logic i_ref_clk,
    // buffer state and pacing
    input wire logic [2:0] i_dec_cnt,
    input wire logic [1:0] i_rnd,
    input wire logic i_stall,
    // towards fetch
    output logic [1:0] o_dec_take,
    output logic o_redirect,
    output logic [31:0] o_redirect_pc,
    output ifb_pkg::ifb_bru_upd_t o_bru_upd
);
    import ifb_pkg::*;
    // ========================================
    // pending requests
    logic redir_req = 1'b0;
    logic [31:0] redir_pc = 32'h0000_0000;
    ifb_bru_upd_t upd_req = '0;

    initial begin
        o_dec_take = 2'h0;
        o_redirect = 1'b0;
        o_redirect_pc = 32'h0000_0000;
        o_bru_upd = '0;
    end

    task automatic send_redirect(input logic [31:0] pc);
        redir_pc = pc;
        redir_req = 1'b1;
    endtask

    task automatic send_train(input logic [31:0] pc, input logic [31:0] tgt, input logic tk);
        upd_req = '{valid: 1'b1, taken: tk, pc: pc, target: tgt};
    endtask

    // ========================================
    // issue and redirect, nothing issues in a flush cycle
    always @(negedge i_ref_clk) begin
        o_dec_take <= (i_stall || redir_req) ? 2'h0 : ((3'(i_rnd) > i_dec_cnt) ? i_dec_cnt[1:0] : i_rnd);
        o_redirect <= redir_req;
        o_redirect_pc <= redir_pc;
        o_bru_upd <= upd_req;
        redir_req = 1'b0;
        upd_req.valid = 1'b0;
    end
endmodule // ifb_dec_unit

// ==== tb_top.sv ====
// tb_top.sv - self-checking bench for the instruction fetch front end
`timescale 1ns/100ps
module tb_top;
    import ifb_pkg::*;
    // ========================================
    // signals
    logic i_ref_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic [3:0][31:0] o_dec_words;
    logic [2:0] o_dec_cnt;
    logic [1:0] i_dec_take;
    logic i_redirect;
    logic [31:0] i_redirect_pc;
    ifb_bru_upd_t i_bru_upd;
    logic [31:0] o_fetch_pc;
    logic o_itlb_req;
    logic [31:0] o_itlb_ea;
    logic i_itlb_fill_valid = 1'b0;
    ifb_itlb_ent_t i_itlb_fill = '0;
    ifb_ibt_ent_t [3:0] ibt_regs = '0;
    logic o_icm_req;
    logic [26:0] o_icm_line;
    logic i_fill_valid = 1'b0;
    logic [63:0] i_fill_data = 64'h0;
    logic o_fill_ready;
    logic [1:0] rnd = 2'h0;
    logic stall = 1'b1;
    logic [31:0] lf = 32'hAABD;
    logic icm_prev = 1'b0;
    logic [3:0][31:0] dw_snap = '0;
    logic [26:0] line_q[$];
    logic [31:0] exp_pc = IFB_RESET_PC;
    logic pv[64] = '{default: 1'b0};
    logic [1:0] pctr[64] = '{default: 2'h0};
    logic [31:0] ptg[64] = '{default: 32'h0};
    int n_errors = 0;
    int comparisons = 0;
    int itlb_fills = 0;

    ifb_fetch u_ifb_fetch (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .o_dec_words(o_dec_words),
        .o_dec_cnt(o_dec_cnt), .i_dec_take(i_dec_take), .i_redirect(i_redirect),
        .i_redirect_pc(i_redirect_pc), .i_bru_upd(i_bru_upd), .o_fetch_pc(o_fetch_pc),
        .o_itlb_req(o_itlb_req), .o_itlb_ea(o_itlb_ea), .i_itlb_fill_valid(i_itlb_fill_valid),
        .i_itlb_fill(i_itlb_fill), .i_insn_block_translation_regs(ibt_regs), .o_icm_req(o_icm_req),
        .o_icm_line(o_icm_line), .i_fill_valid(i_fill_valid), .i_fill_data(i_fill_data),
        .o_fill_ready(o_fill_ready));
    ifb_dec_unit u_ifb_dec_unit (.i_ref_clk(i_ref_clk), .i_dec_cnt(o_dec_cnt), .i_rnd(rnd),
        .i_stall(stall), .o_dec_take(i_dec_take), .o_redirect(i_redirect),
        .o_redirect_pc(i_redirect_pc), .o_bru_upd(i_bru_upd));

    initial begin
        forever #5 i_ref_clk = ~i_ref_clk;
    end

    // ========================================
    // helpers
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] mem_word(input logic [31:0] pa);
        return {~pa[17:2], pa[17:2]};
    endfunction
    function automatic logic [31:0] ea2pa(input logic [31:0] ea);
        if (ea[31:17] == 15'h0002) begin
            return {15'h0005, ea[16:0]};
        end
        return {ea[31:12] ^ 20'h00003, ea[11:0]};
    endfunction
    function automatic logic [31:0] next_pc(input logic [31:0] a);
        if (pv[a[7:2]] && pctr[a[7:2]][1]) begin
            return ptg[a[7:2]];
        end
        return a + IFB_WORD_STEP;
    endfunction
    task automatic train_model(input logic [31:0] pc, input logic [31:0] tgt, input logic tk);
        logic [5:0] ix;
        ix = pc[7:2];
        if (!pv[ix]) begin
            pctr[ix] = tk ? IFB_CTR_WT : IFB_CTR_WNT;
        end else if (tk && pctr[ix] != IFB_CTR_MAX) begin
            pctr[ix] = pctr[ix] + 2'h1;
        end else if (!tk && pctr[ix] != IFB_CTR_MIN) begin
            pctr[ix] = pctr[ix] - 2'h1;
        end
        pv[ix] = 1'b1;
        ptg[ix] = tgt;
    endtask
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic hang();
        n_errors++;
        $display("timeout at %0t", $time);
        give_verdict();
    endtask
    task automatic redirect_to(input logic [31:0] pc);
        int w;
        u_ifb_dec_unit.send_redirect(pc);
        w = 0;
        do begin
            @(posedge i_ref_clk);
            w++;
        end while (!i_redirect && w < 4);
        if (!i_redirect) begin
            hang();
        end
        @(negedge i_ref_clk);
        check(64'(o_fetch_pc), 64'(pc));
        check(64'(o_dec_cnt), 64'h0);
    endtask

    // ========================================
    // reference stream compared at every consumed word
    always @(posedge i_ref_clk) begin
        if (i_nrst) begin
            for (int i = 0; i < 3; i++) begin
                if (i < int'(i_dec_take)) begin
                    check(64'(dw_snap[i]), 64'(mem_word(ea2pa(exp_pc))));
                    exp_pc = next_pc(exp_pc);
                end
            end
            if (i_redirect) begin
                exp_pc = i_redirect_pc;
            end
            if (i_bru_upd.valid) begin
                train_model(i_bru_upd.pc, i_bru_upd.target, i_bru_upd.taken);
            end
        end
    end

    // ========================================
    // pacing and translation refill
    always @(negedge i_ref_clk) begin
        lf <= lfsr_next(lf);
        rnd <= lf[1:0];
        // buffer words as they stand into the next rising edge
        dw_snap <= o_dec_words;
        icm_prev <= o_icm_req;
        if (o_icm_req && !icm_prev) begin
            line_q.push_back(o_icm_line);
        end
        if (i_itlb_fill_valid) begin
            i_itlb_fill_valid <= 1'b0;
        end else if (o_itlb_req) begin
            i_itlb_fill_valid <= 1'b1;
            i_itlb_fill <= '{valid: 1'b1, epn: o_itlb_ea[31:12], rpn: o_itlb_ea[31:12] ^ 20'h00003};
            itlb_fills <= itlb_fills + 1;
        end
    end

    // ========================================
    // line refill source, four beats in address order
    initial begin : fill_src
        logic [26:0] ln;
        int w;
        forever begin
            @(negedge i_ref_clk);
            if (line_q.size() > 0) begin
                ln = line_q.pop_front();
                i_fill_valid <= 1'b1;
                for (int k = 0; k < 4; k++) begin
                    i_fill_data <= {mem_word({ln, 2'(k), 3'h0}), mem_word({ln, 2'(k), 3'h4})};
                    w = 0;
                    while (!o_fill_ready && w < 100) begin
                        @(negedge i_ref_clk);
                        w++;
                    end
                    if (w >= 100) begin
                        hang();
                    end
                    @(negedge i_ref_clk);
                end
                i_fill_valid <= 1'b0;
            end
        end
    end

    initial begin
        #500000;
        hang();
    end

    // ========================================
    // main sequence
    initial begin : main_seq
        logic [31:0] pc_hold;
        int w;
        ibt_regs[0] = '{valid: 1'b1, bepi: 15'h0002, brpn: 15'h0005};
        repeat (5) @(negedge i_ref_clk);
        check(64'(o_dec_cnt), 64'h0);
        check(64'(o_fetch_pc), 64'(IFB_RESET_PC));
        check(64'({o_itlb_req, o_icm_req, o_fill_ready}), 64'h1);
        repeat (5) @(negedge i_ref_clk);
        i_nrst <= 1'b1;
        $display("test reset done");
        stall <= 1'b0;
        repeat (400) @(negedge i_ref_clk);
        $display("test stream done");
        stall <= 1'b1;
        repeat (40) @(negedge i_ref_clk);
        check(64'(o_dec_cnt), 64'(IFB_DEC_DEPTH));
        pc_hold = o_fetch_pc;
        repeat (10) @(negedge i_ref_clk);
        check(64'(o_fetch_pc), 64'(pc_hold));
        $display("test stall done");
        redirect_to(32'h0004_0104);
        w = 0;
        while (o_dec_cnt == 3'h0 && w < 60) begin
            @(negedge i_ref_clk);
            w++;
        end
        check(64'(o_dec_cnt), 64'h1);
        stall <= 1'b0;
        repeat (200) @(negedge i_ref_clk);
        $display("test odd redirect done");
        u_ifb_dec_unit.send_train(32'h0004_0120, 32'h0004_0108, 1'b1);
        redirect_to(32'h0004_0100);
        repeat (200) @(negedge i_ref_clk);
        redirect_to(32'h0004_0120);
        repeat (50) @(negedge i_ref_clk);
        u_ifb_dec_unit.send_train(32'h0004_0120, 32'h0004_0108, 1'b0);
        redirect_to(32'h0004_0100);
        repeat (150) @(negedge i_ref_clk);
        $display("test prediction done");
        redirect_to(32'h0000_3FF8);
        repeat (200) @(negedge i_ref_clk);
        check(64'(itlb_fills >= 3), 64'h1);
        $display("test page cross done");
        give_verdict();
    end
endmodule // tb_top
